// [rtl/serial_dac_input.sv]
// serial-load dac input logic: shift register, word fifo, dac register
// assumes strobes and loads come from an outside controller, asynchronous to both clocks
`timescale 1ns/10ps
`default_nettype none

// ***************************************************
// dual-clock word fifo with gray-coded pointers
// ***************************************************
module word_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 8,
   parameter int AW    = 3
) (
   input  wire  logic             wr_clk_i,
   input  wire  logic             wr_rst_i,
   input  wire  logic             in_valid_i,
   output logic                   in_ready_o,
   input  wire  logic [WIDTH-1:0] in_data_i,
   input  wire  logic             rd_clk_i,
   input  wire  logic             rd_rst_i,
   output logic                   out_valid_o,
   input  wire  logic             out_ready_i,
   output logic       [WIDTH-1:0] out_data_o
);

   // binary to gray, used on both pointers
   function automatic logic [AW:0] to_gray(input logic [AW:0] b);
      to_gray = b ^ (b >> 1);
   endfunction : to_gray

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wbin;
   logic [AW:0]      rbin;
   logic [AW:0]      wgray;
   logic [AW:0]      rgray;
   logic [AW:0]      rgray_s1;
   logic [AW:0]      rgray_s2;
   logic [AW:0]      wgray_s1;
   logic [AW:0]      wgray_s2;
   logic             push;
   logic             pop;

   // full and empty from synchronised gray pointers
   assign in_ready_o  = (wgray != {~rgray_s2[AW:AW-1], rgray_s2[AW-2:0]});
   assign out_valid_o = (rgray != wgray_s2);
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;
   assign out_data_o  = mem[rbin[AW-1:0]];

   // write pointer and storage
   always_ff @(posedge wr_clk_i or posedge wr_rst_i) begin
      if (wr_rst_i) begin
         wbin  <= '0;
         wgray <= '0;
      end else if (push) begin
         wbin  <= wbin + 1'b1;
         wgray <= to_gray(wbin + 1'b1);
      end
   end

   always_ff @(posedge wr_clk_i) begin
      if (push) begin
         mem[wbin[AW-1:0]] <= in_data_i;
      end
   end

   // read pointer into the write domain
   always_ff @(posedge wr_clk_i or posedge wr_rst_i) begin
      if (wr_rst_i) begin
         rgray_s1 <= '0;
         rgray_s2 <= '0;
      end else begin
         rgray_s1 <= rgray;
         rgray_s2 <= rgray_s1;
      end
   end

   // read pointer
   always_ff @(posedge rd_clk_i or posedge rd_rst_i) begin
      if (rd_rst_i) begin
         rbin  <= '0;
         rgray <= '0;
      end else if (pop) begin
         rbin  <= rbin + 1'b1;
         rgray <= to_gray(rbin + 1'b1);
      end
   end

   // write pointer into the read domain
   always_ff @(posedge rd_clk_i or posedge rd_rst_i) begin
      if (rd_rst_i) begin
         wgray_s1 <= '0;
         wgray_s2 <= '0;
      end else begin
         wgray_s1 <= wgray;
         wgray_s2 <= wgray_s1;
      end
   end

endmodule : word_fifo

// ***************************************************
// top: link-side shift and transfer, system-side dac register
// ***************************************************
module serial_dac_input (
   input  wire  logic        clk_i,
   input  wire  logic        rst_i,
   input  wire  logic        link_clk_i,
   input  wire  logic        serial_data_in_i,
   input  wire  logic        shift_strobe_rise_one_i,
   input  wire  logic        shift_strobe_rise_two_i,
   input  wire  logic        shift_strobe_fall_n_i,
   input  wire  logic        shift_strobe_rise_four_i,
   input  wire  logic        transfer_enable_one_n_i,
   input  wire  logic        transfer_enable_two_n_i,
   input  wire  logic        dac_reg_zero_n_i,
   input  wire  logic        update_hold_i,
   output logic       [11:0] dac_code_o,
   output logic              polarity_positive_o,
   output logic              transfer_stall_o
);

   // strobe bits: 0 rise one, 1 rise two, 2 fall (active low), 3 rise four
   logic [3:0]                  strb_s1;
   logic [3:0]                  strb_s2;
   logic [3:0]                  strb_prev;
   logic                        data_s1;
   logic                        data_s2;
   logic [1:0]                  load_s1;
   logic [1:0]                  load_s2;
   // link-domain register a and transfer control
   logic [11:0]                 shift_a;
   logic                        shift_en;
   logic                        loads_low;
   serial_dac_pkg::xfer_state_t xfer_state;
   // fifo handshake on both sides
   logic                        fifo_in_ready;
   logic                        fifo_out_valid;
   logic [11:0]                 fifo_out_data;
   // system-domain release of the clear
   logic                        clear_s1;
   logic                        clear_released;

   // ***************************************************
   // helpers
   // ***************************************************
   // true when the three strobes other than the active one are idle
   function automatic logic others_idle(input logic [3:0] s, input int act);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < 4; i++) begin
         if (i != act) begin
            ok = ok && ((i == 2) ? s[i] : !s[i]);
         end
      end
      others_idle = ok;
   endfunction : others_idle

   // active edge on one strobe, polarity flipped for the falling strobe
   function automatic logic strobe_edge(input logic [3:0] cur, input logic [3:0] prv, input int idx);
      logic act_cur;
      logic act_prv;
      act_cur     = (idx == 2) ? !cur[idx] : cur[idx];
      act_prv     = (idx == 2) ? !prv[idx] : prv[idx];
      strobe_edge = act_cur && !act_prv && others_idle(cur, idx);
   endfunction : strobe_edge

   // ***************************************************
   // link domain: synchronisers
   // ***************************************************
   // strobes reset to idle levels, so no false edge follows reset
   always_ff @(posedge link_clk_i or posedge rst_i) begin
      if (rst_i) begin
         strb_s1   <= serial_dac_pkg::STROBE_IDLE;
         strb_s2   <= serial_dac_pkg::STROBE_IDLE;
         strb_prev <= serial_dac_pkg::STROBE_IDLE;
      end else begin
         strb_s1   <= {shift_strobe_rise_four_i, shift_strobe_fall_n_i,
                       shift_strobe_rise_two_i, shift_strobe_rise_one_i};
         strb_s2   <= strb_s1;
         strb_prev <= strb_s2;
      end
   end

   // serial data, same depth as the strobes so bit and edge stay aligned
   always_ff @(posedge link_clk_i or posedge rst_i) begin
      if (rst_i) begin
         data_s1 <= 1'b0;
         data_s2 <= 1'b0;
      end else begin
         data_s1 <= serial_data_in_i;
         data_s2 <= data_s1;
      end
   end

   // load inputs, idle high
   always_ff @(posedge link_clk_i or posedge rst_i) begin
      if (rst_i) begin
         load_s1 <= serial_dac_pkg::LOAD_IDLE;
         load_s2 <= serial_dac_pkg::LOAD_IDLE;
      end else begin
         load_s1 <= {transfer_enable_two_n_i, transfer_enable_one_n_i};
         load_s2 <= load_s1;
      end
   end

   // edge on one strobe while the rest sit idle
   always_comb begin
      shift_en = 1'b0;
      if (strobe_edge(strb_s2, strb_prev, 0)) shift_en = 1'b1;
      if (strobe_edge(strb_s2, strb_prev, 1)) shift_en = 1'b1;
      if (strobe_edge(strb_s2, strb_prev, 2)) shift_en = 1'b1;
      if (strobe_edge(strb_s2, strb_prev, 3)) shift_en = 1'b1;
   end

   // ***************************************************
   // link domain: register a, msb first
   // ***************************************************
   always_ff @(posedge link_clk_i or posedge rst_i) begin
      if (rst_i) begin
         shift_a <= serial_dac_pkg::REG_ZERO;
      end else if (shift_en) begin
         shift_a <= {shift_a[10:0], data_s2};
      end
   end

   assign loads_low = (load_s2 == 2'b00);

   // one push per load pulse, held until the fifo has room
   always_ff @(posedge link_clk_i or posedge rst_i) begin
      if (rst_i) begin
         xfer_state <= serial_dac_pkg::XFER_IDLE;
      end else begin
         case (xfer_state)
            serial_dac_pkg::XFER_IDLE: begin
               if (loads_low) xfer_state <= serial_dac_pkg::XFER_PUSH;
            end
            serial_dac_pkg::XFER_PUSH: begin
               if (fifo_in_ready) xfer_state <= serial_dac_pkg::XFER_RELEASE;
            end
            serial_dac_pkg::XFER_RELEASE: begin
               if (!loads_low) xfer_state <= serial_dac_pkg::XFER_IDLE;
            end
            default: xfer_state <= serial_dac_pkg::XFER_IDLE;
         endcase
      end
   end

   // ***************************************************
   // crossing: word fifo
   // ***************************************************
   word_fifo #(
      .WIDTH (serial_dac_pkg::WORD_W),
      .DEPTH (serial_dac_pkg::FIFO_DEPTH),
      .AW    (serial_dac_pkg::FIFO_AW)
   ) u_fifo (
      .wr_clk_i    (link_clk_i),
      .wr_rst_i    (rst_i),
      .in_valid_i  (xfer_state == serial_dac_pkg::XFER_PUSH),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (shift_a),
      .rd_clk_i    (clk_i),
      .rd_rst_i    (rst_i),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (!update_hold_i),
      .out_data_o  (fifo_out_data)
   );

   assign transfer_stall_o = !fifo_in_ready;

   // ***************************************************
   // system domain: register b with asynchronous clear
   // ***************************************************
   // clear release retimed onto clk_i, register b stays zero until it lands
   always_ff @(posedge clk_i or posedge rst_i or negedge dac_reg_zero_n_i) begin
      if (rst_i) begin
         clear_s1       <= 1'b0;
         clear_released <= 1'b0;
      end else if (!dac_reg_zero_n_i) begin
         clear_s1       <= 1'b0;
         clear_released <= 1'b0;
      end else begin
         clear_s1       <= 1'b1;
         clear_released <= clear_s1;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i or negedge dac_reg_zero_n_i) begin
      if (rst_i) begin
         dac_code_o <= serial_dac_pkg::REG_ZERO;
      end else if (!dac_reg_zero_n_i) begin
         dac_code_o <= serial_dac_pkg::REG_ZERO;
      end else if (!clear_released) begin
         dac_code_o <= serial_dac_pkg::REG_ZERO;
      end else if (fifo_out_valid && !update_hold_i) begin
         dac_code_o <= fifo_out_data;
      end
   end

   // polarity from the msb, set means at or above mid-scale
   always_ff @(posedge clk_i or posedge rst_i or negedge dac_reg_zero_n_i) begin
      if (rst_i) begin
         polarity_positive_o <= 1'b0;
      end else if (!dac_reg_zero_n_i) begin
         polarity_positive_o <= 1'b0;
      end else if (!clear_released) begin
         polarity_positive_o <= 1'b0;
      end else if (fifo_out_valid && !update_hold_i) begin
         polarity_positive_o <= fifo_out_data[serial_dac_pkg::MSB_POS];
      end
   end

endmodule : serial_dac_input

`default_nettype wire

// [rtl/serial_dac_pkg.sv]
// constants shared by the serial-load dac input logic
// assumes a system clock at 10 MHz and a free-running link sampling clock
`default_nettype none
package serial_dac_pkg;

   // ***************************************************
   // widths, depths and values
   // ***************************************************
   localparam int          WORD_W     = 12;
   localparam int          FIFO_DEPTH = 8;
   localparam int          FIFO_AW    = 3;
   localparam logic [11:0] REG_ZERO   = 12'h000;
   localparam logic [11:0] MID_SCALE  = 12'h800;
   localparam int          MSB_POS    = 11;
   // idle levels, also the synchroniser values after reset
   localparam logic [3:0]  STROBE_IDLE = 4'h4;
   localparam logic [1:0]  LOAD_IDLE   = 2'h3;

   // transfer sequencer on the link side, one-hot
   typedef enum logic [2:0] {
      XFER_IDLE    = 3'b001,
      XFER_PUSH    = 3'b010,
      XFER_RELEASE = 3'b100
   } xfer_state_t;

endpackage : serial_dac_pkg

`default_nettype wire

// [verif/dac_chk_assertions.sv]
// checker of the dac input top ports
// bound to serial_dac_input, clk_i domain only
`timescale 1ns/10ps
`default_nettype none
module dac_chk (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        dac_reg_zero_n_i,
   input wire logic        update_hold_i,
   input wire logic [11:0] dac_code_o,
   input wire logic        polarity_positive_o,
   input wire logic        transfer_stall_o
);
   // ********
   // checks
   // ********
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   a_clear_zero: assert property (!dac_reg_zero_n_i |-> dac_code_o == 12'h000)
      else $error("code not zero");
   a_clear_pol: assert property (!dac_reg_zero_n_i |-> !polarity_positive_o)
      else $error("polarity not low");
   a_pol_msb: assert property (polarity_positive_o == dac_code_o[11])
      else $error("polarity wrong");
   a_hold_code: assert property (update_hold_i [*2] ##0 dac_reg_zero_n_i |-> $stable(dac_code_o))
      else $error("code moved");
   a_rst_zero: assert property ($fell(rst_i) |-> dac_code_o == 12'h000)
      else $error("code not zero");
   a_stall_held: assert property (update_hold_i [*4] ##0 transfer_stall_o |=> transfer_stall_o)
      else $error("stall dropped");
   a_clear_rel: assert property ($rose(dac_reg_zero_n_i) && update_hold_i |-> dac_code_o == 12'h000)
      else $error("code not zero");
   a_clear_stays: assert property (!dac_reg_zero_n_i ##1 !dac_reg_zero_n_i |-> $stable(dac_code_o))
      else $error("code moved");
   a_clear_settle: assert property ($rose(dac_reg_zero_n_i) |=> dac_code_o == 12'h000)
      else $error("code left zero early");
endmodule : dac_chk
bind serial_dac_input dac_chk u_chk (.clk_i, .rst_i, .dac_reg_zero_n_i, .update_hold_i, .dac_code_o,
   .polarity_positive_o, .transfer_stall_o);
`default_nettype wire

// [verif/dac_ctrl_model.sv]
// controller model: serial words and load pulses
// paced by the system clock, one phase a cycle
`timescale 1ns/10ps
`default_nettype none
module dac_ctrl_model (
   input  wire logic       clk_i,
   output logic            sdi_o,
   output logic      [3:0] stb_o,
   output logic      [1:0] ld_n_o
);
   // ********
   // drive tasks
   // ********
   initial begin
      sdi_o <= 1'b0;
      stb_o <= 4'h4;
      ld_n_o <= 2'h3;
   end
   // msb first on strobe sel; bad keeps two strobes busy
   task automatic send(input logic [11:0] w, input int sel, input logic bad);
      logic [3:0] idle;
      idle = bad ? 4'hd : 4'h4;
      for (int i = 11; i >= 0; i--) begin
         @(posedge clk_i) sdi_o <= w[i];
         stb_o <= idle;
         @(posedge clk_i) stb_o <= idle ^ (4'h1 << sel);
         @(posedge clk_i) stb_o <= idle;
      end
      @(posedge clk_i) sdi_o <= ~w[0]; // released line shows the inverse
      stb_o <= 4'h4;
   endtask : send
   // loads low together, or one alone
   task automatic load(input logic [1:0] which_n);
      @(posedge clk_i) ld_n_o <= which_n;
      repeat (2) @(posedge clk_i);
      ld_n_o <= 2'h3;
      repeat (3) @(posedge clk_i);
   endtask : load
endmodule : dac_ctrl_model
`default_nettype wire

// [verif/tb_top.sv]
// bench for the serial dac input top
// model drives strobes and loads; bench drives clear and hold
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   // ********
   // design, model and scenarios
   // ********
   logic        clk_i;
   logic        lclk;
   logic        rst_i;
   logic        clr_n;
   logic        hold;
   logic        sdi, pol, stall;
   logic [3:0]  stb;
   logic [1:0]  ld_n;
   logic [11:0] code;
   int          failures = 0;
   int          checks_done = 0;
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   initial begin
      lclk = 1'b0;
      #7;
      forever #15 lclk = ~lclk;
   end
   serial_dac_input dut (.clk_i, .rst_i, .link_clk_i(lclk), .serial_data_in_i(sdi),
      .shift_strobe_rise_one_i(stb[0]), .shift_strobe_rise_two_i(stb[1]), .shift_strobe_fall_n_i(stb[2]),
      .shift_strobe_rise_four_i(stb[3]), .transfer_enable_one_n_i(ld_n[0]), .transfer_enable_two_n_i(ld_n[1]),
      .dac_reg_zero_n_i(clr_n), .update_hold_i(hold), .dac_code_o(code), .polarity_positive_o(pol),
      .transfer_stall_o(stall));
   dac_ctrl_model ctl (.clk_i, .sdi_o(sdi), .stb_o(stb), .ld_n_o(ld_n));
   task automatic chk_code(input logic [11:0] exp);
      checks_done++;
      if (code !== exp) begin
         failures++;
         $display("unexpected at %0t: code %h not %h", $time, code, exp);
      end
   endtask : chk_code
   task automatic chk_bit(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: flag %b not %b", $time, got, exp);
      end
   endtask : chk_bit
   // wait for a word to land, then compare
   task automatic settle(input logic [11:0] exp);
      for (int i = 0; i < 60 && code !== exp; i++)
         @(negedge clk_i);
      chk_code(exp);
      chk_bit(pol, exp[11]);
   endtask : settle
   task automatic quiet(input logic [11:0] exp);
      repeat (20) @(negedge clk_i);
      chk_code(exp);
   endtask : quiet
   // each strobe in turn, mid and full scale
   task automatic t_strobes;
      logic [11:0] w[4] = '{12'ha5c, 12'h800, 12'h7ff, 12'hfff};
      for (int s = 0; s < 4; s++) begin
         ctl.send(w[s], s, 1'b0);
         ctl.load(2'h0);
         settle(w[s]);
      end
   endtask : t_strobes
   // one load alone, then a spoiled shift
   task automatic t_partial;
      ctl.send(12'h123, 0, 1'b0);
      ctl.load(2'h1);
      ctl.load(2'h2);
      quiet(12'hfff);
      ctl.load(2'h0);
      settle(12'h123);
      ctl.send(12'h5a5, 1, 1'b1);
      ctl.load(2'h0);
      quiet(12'h123);
   endtask : t_partial
   // clear beats a load and spares register a
   task automatic t_clear;
      @(posedge clk_i) clr_n <= 1'b0;
      @(negedge clk_i) chk_code(12'h000);
      chk_bit(pol, 1'b0);
      ctl.load(2'h0);
      quiet(12'h000);
      @(posedge clk_i) hold <= 1'b1;
      @(posedge clk_i) clr_n <= 1'b1;
      @(posedge clk_i) hold <= 1'b0;
      quiet(12'h000);
      ctl.load(2'h0);
      settle(12'h123);
   endtask : t_clear
   // fill the fifo past full while draining stalls
   task automatic t_fifo;
      logic [11:0] w = 12'h0ab;
      @(posedge clk_i) hold <= 1'b1;
      for (int i = 0; i < 9; i++) begin
         w = w + 12'h111;
         ctl.send(w, 3, 1'b0);
         ctl.load(2'h0);
      end
      @(negedge clk_i) chk_bit(stall, 1'b1);
      chk_code(12'h123);
      @(posedge clk_i) hold <= 1'b0;
      settle(w);
      chk_bit(stall, 1'b0);
   endtask : t_fifo
   task automatic summarize;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : summarize
   initial begin
      rst_i <= 1'b1;
      clr_n <= 1'b1;
      hold  <= 1'b0;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      t_strobes();
      t_partial();
      t_clear();
      t_fifo();
      summarize();
   end
   // watchdog, far beyond the run's length
   initial begin
      #1000000;
      failures++;
      summarize();
   end
endmodule : tb_top
`default_nettype wire
